// >>> logic/uvs_defines.svh
// Functional notes
// [RULE_01] answer fixed address 0111001, bonding may change
// [RULE_02] first byte: address, then read/write flag
// [RULE_03] acknowledge accepted bytes, release line otherwise
// [RULE_04] host sends register address, then data
// [RULE_05] host stops after a not-acknowledge
// [RULE_06] host stops after a normal transfer
// [RULE_07] burst write advances pointer per data byte
// [RULE_08] burst write ends only on stop; the target also ends it on a repeated start
// [RULE_09] host sets pointer by short write first
// [RULE_10] host restarts with address and read flag
// [RULE_11] read returns register at set pointer
// [RULE_12] further read bytes come from rising addresses
// [RULE_13] host ends read with stop
// [RULE_14] host refuses last byte; target then releases
`ifndef UVS_DEFINES_SVH
`define UVS_DEFINES_SVH

// target address and the alternative selected by the bonding strap
`define UVS_DEV_ADDR 7'h39
// alternative address value is arbitrary
`define UVS_ALT_ADDR 7'h3A
// bit counter marks
`define UVS_BYTE_BITS 4'h8
`define UVS_LAST_TX_BIT 4'h7
// pointer step
`define UVS_PTR_STEP 8'h01
// number of pins passing the synchroniser
`define UVS_SYNC_W 3

`endif

// >>> logic/uvs_i2c_target.sv
`timescale 1ns/100ps
// two-wire target port: oversamples the host clock and data with mclk
module uvs_i2c_target
    import uvs_pkg::*;
(
    input wire logic mclk, // 20 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic scl_in, // serial clock pin level
    input wire logic sda_in, // serial data pin level
    input wire logic addr_alt_sel, // bonding strap, high picks the alternative address
    output logic sda_out, // data drive value, always low (open drain)
    output logic sda_oe, // high while the target pulls data low
    output uvs_reg_req_t reg_req, // pointer, write data, write strobe
    input wire logic [7:0] reg_rdata // register file data at reg_req.addr
);
    logic [2:0] pin_lvl; // synchronised {strap, sda, scl}
    logic [2:0] pin_prv; // previous synchronised levels

    // every pin passes two flops before any decoding
    uvs_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in({addr_alt_sel, sda_in, scl_in}),
        .lvl(pin_lvl),
        .prv(pin_prv)
    );

    logic scl_rise; // host clock rising
    logic scl_fall; // host clock falling
    logic start_evt; // data falls while clock high (start or repeated start)
    logic stop_evt; // data rises while clock high
    logic [6:0] own_addr; // address in use

    assign scl_rise = pin_lvl[0] & ~pin_prv[0];
    assign scl_fall = ~pin_lvl[0] & pin_prv[0];
    assign start_evt = pin_lvl[0] & pin_prv[0] & pin_prv[1] & ~pin_lvl[1];
    assign stop_evt = pin_lvl[0] & pin_prv[0] & ~pin_prv[1] & pin_lvl[1];
    assign own_addr = pin_lvl[2] ? `UVS_ALT_ADDR : `UVS_DEV_ADDR; // [RULE_01]

    uvs_state_t state_ff, nxt_state; // byte engine state
    logic [3:0] bitcnt_ff, nxt_bitcnt; // bits moved in the current byte
    logic [7:0] shift_ff, nxt_shift; // receive or transmit shifter
    logic [7:0] ptr_ff, nxt_ptr; // auto-incrementing register pointer
    logic first_ff, nxt_first; // current byte is the address byte
    logic got_ptr_ff, nxt_got_ptr; // pointer byte already taken in this write
    logic read_ff, nxt_read; // direction flag of this transfer
    logic sda_oe_ff, nxt_sda_oe; // data pull-down enable
    logic sda_out_ff; // drive value register
    uvs_reg_req_t req_ff, nxt_req; // request to the register file

    // next-state logic; start and stop override any byte in flight
    always_comb begin
        nxt_state = state_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_shift = shift_ff;
        nxt_ptr = ptr_ff;
        nxt_first = first_ff;
        nxt_got_ptr = got_ptr_ff;
        nxt_read = read_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_req.addr = ptr_ff;
        nxt_req.wdata = req_ff.wdata;
        nxt_req.wr = 1'h0;
        if (stop_evt) begin
            // stop closes any sequence, burst writes included
            nxt_state = UVS_IDLE; // [RULE_08]
            nxt_sda_oe = 1'h0;
        end else if (start_evt) begin
            // pointer is kept across a repeated start so a read follows it
            nxt_state = UVS_RX; // [RULE_02]
            nxt_first = 1'h1;
            nxt_got_ptr = 1'h0;
            nxt_bitcnt = 4'h0;
            nxt_sda_oe = 1'h0;
        end else begin
            case (state_ff)
                UVS_RX: begin
                    if (scl_rise && bitcnt_ff != `UVS_BYTE_BITS) begin
                        nxt_shift = {shift_ff[6:0], pin_lvl[1]};
                        nxt_bitcnt = 4'(bitcnt_ff + 4'h1);
                    end else if (scl_fall && bitcnt_ff == `UVS_BYTE_BITS) begin
                        nxt_state = UVS_ACK;
                        nxt_sda_oe = 1'h1; // [RULE_03]
                        if (first_ff) begin
                            nxt_read = shift_ff[0]; // [RULE_02]
                            if (shift_ff[7:1] != own_addr) begin
                                // not for us: leave the line released
                                nxt_state = UVS_WAIT; // [RULE_03]
                                nxt_sda_oe = 1'h0;
                            end
                        end else if (!got_ptr_ff) begin
                            nxt_ptr = shift_ff; // [RULE_04]
                            nxt_got_ptr = 1'h1;
                        end else begin
                            // store and step; every data byte is taken until stop or start
                            nxt_req.addr = ptr_ff;
                            nxt_req.wdata = shift_ff;
                            nxt_req.wr = 1'h1; // [RULE_08]
                            nxt_ptr = 8'(ptr_ff + `UVS_PTR_STEP); // [RULE_07]
                        end
                    end
                end
                UVS_ACK: begin
                    if (scl_fall) begin
                        nxt_bitcnt = 4'h0;
                        if (first_ff && read_ff) begin
                            // first read byte comes from the pointer set earlier
                            nxt_state = UVS_TX;
                            nxt_shift = reg_rdata; // [RULE_11]
                            nxt_sda_oe = ~reg_rdata[7];
                        end else begin
                            nxt_state = UVS_RX;
                            nxt_sda_oe = 1'h0;
                        end
                        nxt_first = 1'h0;
                    end
                end
                UVS_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_ff == `UVS_LAST_TX_BIT) begin
                            nxt_state = UVS_HACK;
                            nxt_sda_oe = 1'h0;
                            nxt_ptr = 8'(ptr_ff + `UVS_PTR_STEP); // [RULE_12]
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'h0};
                            nxt_sda_oe = ~shift_ff[6];
                            nxt_bitcnt = 4'(bitcnt_ff + 4'h1);
                        end
                    end
                end
                UVS_HACK: begin
                    // low bit of the shifter keeps the sampled host answer
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[7:1], pin_lvl[1]};
                    end else if (scl_fall) begin
                        nxt_bitcnt = 4'h0;
                        if (!shift_ff[0]) begin
                            nxt_state = UVS_TX; // [RULE_12]
                            nxt_shift = reg_rdata;
                            nxt_sda_oe = ~reg_rdata[7];
                        end else begin
                            // host refused: stay off the line until stop or start
                            nxt_state = UVS_WAIT; // [RULE_14]
                        end
                    end
                end
                UVS_IDLE, UVS_WAIT: begin
                    nxt_sda_oe = 1'h0; // [RULE_14]
                end
                default: begin
                    nxt_state = UVS_IDLE;
                    nxt_sda_oe = 1'h0;
                end
            endcase
        end
    end

    // state registers only
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= UVS_IDLE;
            bitcnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            first_ff <= 1'h0;
            got_ptr_ff <= 1'h0;
            read_ff <= 1'h0;
            sda_oe_ff <= 1'h0;
            sda_out_ff <= 1'h0;
            req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            bitcnt_ff <= nxt_bitcnt;
            shift_ff <= nxt_shift;
            ptr_ff <= nxt_ptr;
            first_ff <= nxt_first;
            got_ptr_ff <= nxt_got_ptr;
            read_ff <= nxt_read;
            sda_oe_ff <= nxt_sda_oe;
            sda_out_ff <= 1'h0;
            req_ff <= nxt_req;
        end
    end

    assign sda_out = sda_out_ff;
    assign sda_oe = sda_oe_ff;
    assign reg_req = req_ff;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic addr_done; // address byte complete at this clock fall
    assign addr_done = state_ff == UVS_RX && first_ff && scl_fall && bitcnt_ff == `UVS_BYTE_BITS;

    AST_ADDR_MATCH_ACK: assert property ( // [RULE_01]
        addr_done && shift_ff[7:1] == own_addr |=> sda_oe_ff && state_ff == UVS_ACK)
        else $error("own address not acknowledged");
    AST_ADDR_MISS_NACK: assert property ( // [RULE_03]
        addr_done && shift_ff[7:1] != own_addr |=> !sda_oe_ff [*2])
        else $error("foreign address drove the line");
    AST_DIR_FLAG: assert property ( // [RULE_02]
        addr_done |=> read_ff == $past(shift_ff[0]))
        else $error("direction flag not taken from bit 0");
    AST_START_ADDR: assert property ( // [RULE_02]
        start_evt && !stop_evt |=> state_ff == UVS_RX && first_ff && bitcnt_ff == 4'h0)
        else $error("start did not open an address byte");
    AST_WR_STEP: assert property ( // [RULE_07]
        req_ff.wr |-> ptr_ff == 8'(req_ff.addr + `UVS_PTR_STEP) && !read_ff)
        else $error("pointer not advanced after a stored byte");
    AST_STOP_ENDS: assert property ( // [RULE_08]
        stop_evt |=> state_ff == UVS_IDLE && !sda_oe_ff && !req_ff.wr)
        else $error("stop did not end the sequence");
    AST_READ_LOAD: assert property ( // [RULE_11]
        state_ff == UVS_ACK && first_ff && read_ff && scl_fall && !start_evt && !stop_evt
        |=> state_ff == UVS_TX && shift_ff == $past(reg_rdata))
        else $error("read byte not loaded from the pointer");
    AST_READ_STEP: assert property ( // [RULE_12]
        state_ff == UVS_TX && bitcnt_ff == `UVS_LAST_TX_BIT && scl_fall && !start_evt && !stop_evt
        |=> ptr_ff == 8'($past(ptr_ff) + `UVS_PTR_STEP) && state_ff == UVS_HACK)
        else $error("pointer not stepped after a read byte");
    AST_NACK_RELEASE: assert property ( // [RULE_14]
        state_ff == UVS_HACK && shift_ff[0] && scl_fall && !start_evt && !stop_evt
        |=> state_ff == UVS_WAIT && !sda_oe_ff)
        else $error("line still driven after host refusal");

    COV_WRITE: cover property (req_ff.wr ##[1:1000] req_ff.wr);
    COV_READ: cover property (state_ff == UVS_HACK ##1 state_ff == UVS_TX);
    COV_NACK: cover property (state_ff == UVS_WAIT ##[1:1000] stop_evt);
    COV_RESTART: cover property (state_ff == UVS_RX && got_ptr_ff ##1 start_evt);
endmodule : uvs_i2c_target

// >>> logic/uvs_pkg.sv
package uvs_pkg;
`include "uvs_defines.svh"

    // byte engine states
    typedef enum logic [2:0] {
        UVS_IDLE = 3'h0, // bus free, entered on reset or stop
        UVS_RX = 3'h1, // shifting in a byte from the host
        UVS_ACK = 3'h2, // target driving acknowledge bit
        UVS_TX = 3'h3, // shifting out a read byte
        UVS_HACK = 3'h4, // host acknowledge slot after a read byte
        UVS_WAIT = 3'h5 // released, waiting for stop or start
    } uvs_state_t;

    // request towards the register file
    typedef struct packed {
        logic [7:0] addr; // register pointer
        logic [7:0] wdata; // byte to store
        logic wr; // one-cycle write strobe
    } uvs_reg_req_t;

endpackage : uvs_pkg

// >>> logic/uvs_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser plus one history stage for edge finding
module uvs_sync
    import uvs_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [`UVS_SYNC_W-1:0] async_in, // raw pins
    output logic [`UVS_SYNC_W-1:0] lvl, // synchronised level
    output logic [`UVS_SYNC_W-1:0] prv // level one cycle earlier
);
    logic [`UVS_SYNC_W-1:0] meta_ff; // first stage, read only by second
    logic [`UVS_SYNC_W-1:0] lvl_ff; // second stage
    logic [`UVS_SYNC_W-1:0] prv_ff; // history for edge detection

    genvar gi;
    generate
        for (gi = 0; gi < `UVS_SYNC_W; gi++) begin : g_bit
            // reset to idle-high so no false edge appears after reset
            always_ff @(posedge mclk) begin
                if (rst) begin
                    meta_ff[gi] <= 1'h1;
                    lvl_ff[gi] <= 1'h1;
                    prv_ff[gi] <= 1'h1;
                end else begin
                    meta_ff[gi] <= async_in[gi];
                    lvl_ff[gi] <= meta_ff[gi];
                    prv_ff[gi] <= lvl_ff[gi];
                end
            end
        end
    endgenerate

    assign lvl = lvl_ff;
    assign prv = prv_ff;
endmodule : uvs_sync

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    import uvs_pkg::*;
    logic mclk; // 20 MHz system clock
    logic rst; // synchronous reset
    logic addr_alt_sel; // bonding strap
    logic scl; // host serial clock
    logic host_low; // host pulls data low
    logic sda_out; // target drive value
    logic sda_oe; // target pulls data low
    wire logic sda_line; // pulled-up data wire
    uvs_reg_req_t reg_req; // register file request
    logic [7:0] reg_rdata; // register file read data
    logic [7:0] mem [256]; // register file seen by the design
    logic [7:0] exp_mem [256]; // shadow kept from stimulus only
    logic [7:0] exp_ptr; // pointer the target should hold
    logic [15:0] wr_q [$]; // expected {addr, data} of each write
    int err_count;
    int compares;

    // open drain: any party pulling wins, else the pull-up
    assign sda_line = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    always_comb reg_rdata = mem[reg_req.addr];

    uvs_i2c_target uut (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .addr_alt_sel(addr_alt_sel), .sda_out(sda_out), .sda_oe(sda_oe),
        .reg_req(reg_req), .reg_rdata(reg_rdata));
    uvs_host_model host (.mclk(mclk), .scl(scl), .sda_low(host_low), .sda_line(sda_line));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string what);
        chk8({7'h00, got}, {7'h00, exp}, what);
    endtask : chk1

    // each strobe takes the oldest note; a stray strobe meets an unknown
    always @(posedge mclk) begin
        logic [15:0] e;
        if (reg_req.wr === 1'b1) begin
            e = (wr_q.size() != 0) ? wr_q.pop_front() : 16'hXXXX;
            chk8(reg_req.addr, e[15:8], "write address");
            chk8(reg_req.wdata, e[7:0], "write data");
            mem[reg_req.addr] <= reg_req.wdata;
        end
    end

    // pointer byte then n data bytes; ack_ok says if the address should match
    task automatic xfer_write(input logic [6:0] dev, input logic [7:0] ptr, input int n, input logic ack_ok);
        logic a;
        logic [7:0] d;
        host.bus_start();
        host.put_byte({dev, 1'b0}, a);
        chk1(a, ack_ok, "address ack");
        if (ack_ok) begin
            host.put_byte(ptr, a);
            chk1(a, 1'b1, "pointer ack");
            exp_ptr = ptr;
            for (int i = 0; i < n; i++) begin
                d = 8'($urandom);
                wr_q.push_back({exp_ptr, d});
                exp_mem[exp_ptr] = d;
                exp_ptr++;
                host.put_byte(d, a);
                chk1(a, 1'b1, "data ack");
            end
        end
        host.bus_stop();
    endtask : xfer_write

    // read stage: n bytes, the last one refused by the host
    task automatic xfer_read(input logic [6:0] dev, input int n);
        logic a;
        logic [7:0] b;
        host.bus_start();
        host.put_byte({dev, 1'b1}, a);
        chk1(a, 1'b1, "read address ack");
        for (int i = 0; i < n; i++) begin
            host.get_byte(i == n - 1, b);
            chk8(b, exp_mem[exp_ptr], "read data");
            exp_ptr++;
        end
        host.bus_stop();
        chk1(sda_oe, 1'b0, "released after stop");
        chk1(sda_out, 1'b0, "drive value low");
    endtask : xfer_read

    task automatic give_verdict();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // twelve transfers take about 160 us; past 400 us the run has hung
    initial begin
        #400000;
        err_count++;
        give_verdict();
    end

    initial begin
        logic [6:0] own;
        logic [6:0] other;
        logic [7:0] p;
        err_count = 0;
        compares = 0;
        void'($urandom(16019));
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($urandom);
            exp_mem[i] = mem[i];
        end
        rst = 1'b1;
        addr_alt_sel = 1'b0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk1(sda_oe, 1'b0, "reset drive");
        chk8(reg_req.addr, 8'h00, "reset pointer");
        chk1(reg_req.wr, 1'b0, "reset strobe");
        // both strap settings; the wrong address must be ignored each time
        for (int sel = 0; sel < 2; sel++) begin
            @(posedge mclk);
            addr_alt_sel <= sel[0];
            own = sel ? `UVS_ALT_ADDR : `UVS_DEV_ADDR;
            other = sel ? `UVS_DEV_ADDR : `UVS_ALT_ADDR;
            p = 8'($urandom);
            xfer_write(other, p, 0, 1'b0);
            xfer_write(own, p, 3, 1'b1);
            xfer_write(own, p, 0, 1'b1);
            xfer_read(own, 4);
            xfer_read(own, 1);
            xfer_write(own, 8'hFE, 3, 1'b1);
        end
        chk1(wr_q.size() == 0, 1'b1, "writes outstanding");
        give_verdict();
    end
endmodule : testbench

// >>> verification/uvs_host_model.sv
`timescale 1ns/100ps
// behavioural bus controller: 400 ns bit period (8 mclk), open drain on data
// pins change by non-blocking update at a rising mclk edge, so the target's
// synchroniser always takes them one edge later with no race
// scl idles high between frames, as the pull-up leaves it
module uvs_host_model (
    input wire logic mclk, // bench clock, paces every pin change
    output logic scl, // serial clock, driven by the host only
    output logic sda_low, // high while the host pulls data low
    input wire logic sda_line // resolved data line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // start or repeated start; leaves scl low
    task automatic bus_start();
        sda_low <= 1'b0;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
        sda_low <= 1'b1;
        repeat (4) @(posedge mclk);
        scl <= 1'b0;
    endtask : bus_start

    // stop releases the bus after every transfer, refused or not
    task automatic bus_stop();
        repeat (2) @(posedge mclk);
        sda_low <= 1'b1;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
        sda_low <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : bus_stop

    // byte out msb first, then sample the target's answer
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            repeat (2) @(posedge mclk);
            sda_low <= ~b[i];
            repeat (2) @(posedge mclk);
            scl <= 1'b1;
            repeat (4) @(posedge mclk);
            scl <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        sda_low <= 1'b0; // release for the ack slot
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (2) @(posedge mclk);
        ack = ~sda_line;
        repeat (2) @(posedge mclk);
        scl <= 1'b0;
    endtask : put_byte

    // byte in; refuse it when it is the last one wanted
    task automatic get_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            repeat (2) @(posedge mclk);
            sda_low <= 1'b0;
            repeat (2) @(posedge mclk);
            scl <= 1'b1;
            repeat (2) @(posedge mclk);
            b[i] = sda_line;
            repeat (2) @(posedge mclk);
            scl <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        sda_low <= ~last;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
        scl <= 1'b0;
    endtask : get_byte
endmodule : uvs_host_model
